// ---- common/timekeeper_consts.vh ----
`ifndef TIMEKEEPER_CONSTS_VH
`define TIMEKEEPER_CONSTS_VH

// ****************************************************************
// Clock and timing
// ****************************************************************
`define CLK_MHZ        250
`define TICK_US        10000
`define SETTLE_US      200000
`define TICK_W         22
`define SETTLE_W       26

// ****************************************************************
// Bus and memory geometry
// ****************************************************************
`define ADDR_BITS      15
`define DATA_W         8
`define MEM_DEPTH      32768
`define NUM_TK_REGS    14

// ****************************************************************
// Register offsets
// ****************************************************************
`define REG_HUND       4'h0
`define REG_SEC        4'h1
`define REG_MIN        4'h2
`define REG_MIN_ALM    4'h3
`define REG_HOUR       4'h4
`define REG_HOUR_ALM   4'h5
`define REG_DAY        4'h6
`define REG_DAY_ALM    4'h7
`define REG_DATE       4'h8
`define REG_MONTH      4'h9
`define REG_YEAR       4'hA
`define REG_CMD        4'hB
`define REG_WD_LO      4'hC
`define REG_WD_HI      4'hD

// ****************************************************************
// Field positions
// ****************************************************************
`define CMD_TE         7
`define CMD_IPSW       6
`define CMD_WAM        3
`define CMD_TAM        2
`define CMD_WDF        1
`define CMD_TDF        0
`define MON_EOSC       7
`define HR_12          6
`define HR_PM          5
`define ALM_MASK       7

// ****************************************************************
// Writable bit masks (unused bits read zero)
// ****************************************************************
`define WM_HUND        8'hFF
`define WM_SEC         8'h7F
`define WM_HOUR        8'h7F
`define WM_ALM         8'hFF
`define WM_DAY         8'h07
`define WM_DAY_ALM     8'h87
`define WM_DATE        8'h3F
`define WM_MONTH       8'hDF
`define WM_MON_FIELD   8'h1F
`define WM_CMD         8'hFC
`define WM_HR_FIELD    8'h1F
`define WM_HR24        8'h3F
`define WM_ALL         8'hFF

// ****************************************************************
// Reset values and BCD limits
// ****************************************************************
`define RST_ZERO       8'h00
`define RST_ONE        8'h01
`define RST_CMD        8'h8C
`define BCD_MAX99      8'h99
`define BCD_MAX59      8'h59
`define BCD_MAX23      8'h23
`define BCD_11         8'h11
`define BCD_12         8'h12
`define BCD_7          8'h07
`define BCD_FEB        8'h02
`define BCD_APR        8'h04
`define BCD_JUN        8'h06
`define BCD_SEP        8'h09
`define DAYS_28        8'h28
`define DAYS_29        8'h29
`define DAYS_30        8'h30
`define DAYS_31        8'h31
`define BCD_DIGIT9     4'h9

`endif

// ---- verilog/user_ram.v ----
`timescale 1ns/10ps
module user_ram #(
  parameter ADDR_W = 15,
  parameter DATA_W = 8,
  parameter DEPTH  = 32768
)(
  // Clock
  input  wire              clock,
  // Write side
  input  wire              wr_en,
  input  wire [ADDR_W-1:0] wr_addr,
  input  wire [DATA_W-1:0] wr_data,
  // Read side
  input  wire [ADDR_W-1:0] rd_addr,
  output reg  [DATA_W-1:0] rd_data
);

  reg [DATA_W-1:0] mem [0:DEPTH-1];

  // Contents are not reset: they model battery-held storage
  always @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule // user_ram

// ---- verilog/timekeeper_port.v ----
`timescale 1ns/10ps
`include "timekeeper_consts.vh"
module timekeeper_port #(
  parameter ADDR_W        = `ADDR_BITS,
  parameter MEM_DEPTH     = `MEM_DEPTH,
  parameter TICK_CYCLES   = `TICK_US * `CLK_MHZ,
  parameter SETTLE_CYCLES = `SETTLE_US * `CLK_MHZ
)(
  // Clock and reset
  input  wire                clock,
  input  wire                rst_b,
  // Host memory bus
  input  wire [ADDR_W-1:0]   addr_in,
  input  wire [`DATA_W-1:0]  data_io_in,
  output wire [`DATA_W-1:0]  data_io_out,
  output wire                data_io_oe,
  input  wire                chip_sel_b,
  input  wire                out_strobe_b,
  input  wire                wr_strobe_b,
  // Supply monitor
  input  wire                supply_fail,
  input  wire                supply_good,
  // Interrupts, active low
  output wire                interrupt_out_a_b,
  output wire                interrupt_out_b_b
);

  // ****************************************************************
  // Functions
  // ****************************************************************
  function [7:0] bcd_inc;
    input [7:0] v;
    begin
      if (v[3:0] == `BCD_DIGIT9) begin
        bcd_inc = {v[7:4] + 4'h1, 4'h0};
      end else begin
        bcd_inc = {v[7:4], v[3:0] + 4'h1};
      end
    end
  endfunction

  function [6:0] bcd_to_bin;
    input [7:0] v;
    begin
      bcd_to_bin = {v[7:4], 3'b000} + {2'b00, v[7:4], 1'b0} + {3'b000, v[3:0]};
    end
  endfunction

  // Year divisible by four: units low bits match twice the tens parity
  function [7:0] days_in_month;
    input [7:0] mon;
    input [7:0] yr;
    begin
      case (mon)
        `BCD_FEB: days_in_month = (yr[1:0] == {yr[4], 1'b0}) ? `DAYS_29 : `DAYS_28;
        `BCD_APR, `BCD_JUN, `BCD_SEP, `BCD_11: days_in_month = `DAYS_30;
        default: days_in_month = `DAYS_31;
      endcase
    end
  endfunction

  function [7:0] wr_mask;
    input [3:0] idx;
    begin
      case (idx)
        `REG_SEC, `REG_MIN:                     wr_mask = `WM_SEC;
        `REG_HOUR:                              wr_mask = `WM_HOUR;
        `REG_MIN_ALM, `REG_HOUR_ALM:            wr_mask = `WM_ALM;
        `REG_DAY:                               wr_mask = `WM_DAY;
        `REG_DAY_ALM:                           wr_mask = `WM_DAY_ALM;
        `REG_DATE:                              wr_mask = `WM_DATE;
        `REG_MONTH:                             wr_mask = `WM_MONTH;
        `REG_CMD:                               wr_mask = `WM_CMD;
        default:                                wr_mask = `WM_ALL;
      endcase
    end
  endfunction

  function [7:0] rst_val;
    input [3:0] idx;
    begin
      case (idx)
        `REG_DAY, `REG_DATE, `REG_MONTH: rst_val = `RST_ONE;
        `REG_CMD:                        rst_val = `RST_CMD;
        default:                         rst_val = `RST_ZERO;
      endcase
    end
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  localparam BUS_W  = ADDR_W + `DATA_W + 5;
  localparam P_DATA = ADDR_W;
  localparam P_CS   = ADDR_W + `DATA_W;
  localparam P_OE   = P_CS + 1;
  localparam P_WE   = P_CS + 2;
  localparam P_FAIL = P_CS + 3;
  localparam P_GOOD = P_CS + 4;

  wire [BUS_W-1:0] pins_in = {supply_good, supply_fail, wr_strobe_b, out_strobe_b,
                              chip_sel_b, data_io_in, addr_in};
  reg  [BUS_W-1:0] sync1_ff;
  reg  [BUS_W-1:0] sync2_ff;
  reg  [BUS_W-1:0] sync3_ff;
  reg  [BUS_W-1:0] clean_ff;
  wire [BUS_W-1:0] settle = ~(sync2_ff ^ sync3_ff);
  wire [BUS_W-1:0] nxt_clean = (sync3_ff & settle) | (clean_ff & ~settle);
  // Strobes idle high so no spurious access appears out of reset
  localparam [BUS_W-1:0] PINS_IDLE = {2'b00, 3'b111, {(BUS_W-5){1'b0}}};

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sync1_ff <= PINS_IDLE;
      sync2_ff <= PINS_IDLE;
      sync3_ff <= PINS_IDLE;
      clean_ff <= PINS_IDLE;
    end else begin
      sync1_ff <= pins_in;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      clean_ff <= nxt_clean;
    end
  end

  wire [ADDR_W-1:0]  s_addr = clean_ff[ADDR_W-1:0];
  wire [`DATA_W-1:0] s_data = clean_ff[P_DATA +: `DATA_W];

  // ****************************************************************
  // Supply protection
  // ****************************************************************
  localparam [2:0] ST_PROT   = 3'b001;
  localparam [2:0] ST_SETTLE = 3'b010;
  localparam [2:0] ST_RUN    = 3'b100;
  localparam integer         SETTLE_END  = SETTLE_CYCLES - 1;
  localparam [`SETTLE_W-1:0] SETTLE_LAST = SETTLE_END[`SETTLE_W-1:0];

  reg [2:0]           pwr_st_ff;
  reg [`SETTLE_W-1:0] settle_cnt_ff;
  wire                protect = ~pwr_st_ff[2];

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pwr_st_ff     <= ST_PROT;
      settle_cnt_ff <= {`SETTLE_W{1'b0}};
    end else if (clean_ff[P_FAIL] || !clean_ff[P_GOOD]) begin
      pwr_st_ff     <= ST_PROT;
      settle_cnt_ff <= {`SETTLE_W{1'b0}};
    end else begin
      case (pwr_st_ff)
        ST_PROT: pwr_st_ff <= ST_SETTLE;
        ST_SETTLE: begin
          settle_cnt_ff <= settle_cnt_ff + 1'b1;
          if (settle_cnt_ff == SETTLE_LAST) begin
            pwr_st_ff <= ST_RUN;
          end
        end
        ST_RUN: pwr_st_ff <= ST_RUN;
        default: pwr_st_ff <= ST_PROT;
      endcase
    end
  end

  // ****************************************************************
  // Bus access decode
  // ****************************************************************
  wire wr_cond = ~clean_ff[P_CS] & ~clean_ff[P_WE] & ~protect;
  wire rd_act  = ~clean_ff[P_CS] & ~clean_ff[P_OE] & clean_ff[P_WE] & ~protect;
  wire is_reg  = (s_addr < `NUM_TK_REGS);

  reg              wr_act_ff;
  reg [ADDR_W-1:0] wr_addr_ff;
  reg [7:0]        wr_data_ff;
  reg              rd_act_ff;
  reg [ADDR_W-1:0] rd_addr_ff;

  // Data is resampled every cycle of the write, so the last value before
  // the ending edge is the one committed.
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wr_act_ff  <= 1'b0;
      wr_addr_ff <= {ADDR_W{1'b0}};
      wr_data_ff <= 8'h00;
      rd_act_ff  <= 1'b0;
      rd_addr_ff <= {ADDR_W{1'b0}};
    end else begin
      wr_act_ff  <= wr_cond;
      rd_act_ff  <= rd_act;
      rd_addr_ff <= s_addr;
      if (wr_cond) begin
        wr_addr_ff <= s_addr;
        wr_data_ff <= s_data;
      end
    end
  end

  // A write dropped by supply fail mid-cycle is not committed
  wire       commit     = wr_act_ff & ~wr_cond & ~protect;
  wire       wr_reg     = commit & (wr_addr_ff < `NUM_TK_REGS);
  wire [3:0] wr_idx     = wr_addr_ff[3:0];
  wire       rd_start   = rd_act & (~rd_act_ff | (s_addr != rd_addr_ff));
  wire [3:0] rd_idx     = s_addr[3:0];
  wire       rd_reg     = rd_start & is_reg;
  wire       wd_access  = (wr_reg & ((wr_idx == `REG_WD_LO) | (wr_idx == `REG_WD_HI))) |
                          (rd_reg & ((rd_idx == `REG_WD_LO) | (rd_idx == `REG_WD_HI)));
  wire       alm_access = (wr_reg & ((wr_idx == `REG_MIN_ALM) | (wr_idx == `REG_HOUR_ALM) |
                                     (wr_idx == `REG_DAY_ALM))) |
                          (rd_reg & ((rd_idx == `REG_MIN_ALM) | (rd_idx == `REG_HOUR_ALM) |
                                     (rd_idx == `REG_DAY_ALM)));

  // ****************************************************************
  // Hundredth-second tick
  // ****************************************************************
  localparam integer       TICK_END  = TICK_CYCLES - 1;
  localparam [`TICK_W-1:0] TICK_LAST = TICK_END[`TICK_W-1:0];

  reg  [7:0]         ext_ff [0:`NUM_TK_REGS-1];
  reg  [`TICK_W-1:0] tick_cnt_ff;
  wire               osc_on = ~ext_ff[`REG_MONTH][`MON_EOSC];
  wire               tick   = osc_on & (tick_cnt_ff == TICK_LAST);

  // Runs regardless of the supply state
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_ff <= {`TICK_W{1'b0}};
    end else if (!osc_on || tick) begin
      tick_cnt_ff <= {`TICK_W{1'b0}};
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 1'b1;
    end
  end

  // ****************************************************************
  // Internal time chain
  // ****************************************************************
  reg [7:0] hund_ff, sec_ff, min_ff, hour_ff, day_ff, date_ff, mon_ff, year_ff;
  reg [7:0] nxt_hund, nxt_sec, nxt_min, nxt_hour, nxt_day, nxt_date, nxt_mon, nxt_year;
  reg       c_sec, c_min, c_hr, c_day, c_mon;
  reg [7:0] month_len;
  reg [7:0] hr_inc;

  wire       mode12  = hour_ff[`HR_12];
  wire [7:0] hr_fld  = mode12 ? (hour_ff & `WM_HR_FIELD) : (hour_ff & `WM_HR24);

  always @* begin
    month_len = days_in_month(mon_ff, year_ff);
    hr_inc    = bcd_inc({3'b000, hr_fld[4:0]});
    c_sec     = (hund_ff == `BCD_MAX99);
    c_min     = c_sec & (sec_ff == `BCD_MAX59);
    c_hr      = c_min & (min_ff == `BCD_MAX59);
    c_day     = c_hr & (mode12 ? ((hr_fld == `BCD_11) & hour_ff[`HR_PM])
                               : (hr_fld == `BCD_MAX23));
    c_mon     = c_day & (date_ff == month_len);
    nxt_hund  = c_sec ? `RST_ZERO : bcd_inc(hund_ff);
    nxt_sec   = c_min ? `RST_ZERO : (c_sec ? bcd_inc(sec_ff) : sec_ff);
    nxt_min   = c_hr ? `RST_ZERO : (c_min ? bcd_inc(min_ff) : min_ff);
    nxt_hour  = hour_ff;
    if (c_hr) begin
      if (!mode12) begin
        nxt_hour = c_day ? `RST_ZERO : bcd_inc(hour_ff);
      end else if (hr_fld == `BCD_12) begin
        nxt_hour = {hour_ff[7:5], 5'h01};
      end else if (hr_fld == `BCD_11) begin
        nxt_hour = {hour_ff[7:6], ~hour_ff[`HR_PM], 5'h12};
      end else begin
        nxt_hour = {hour_ff[7:5], hr_inc[4:0]};
      end
    end
    nxt_day   = c_day ? ((day_ff == `BCD_7) ? `RST_ONE : bcd_inc(day_ff)) : day_ff;
    nxt_date  = c_mon ? `RST_ONE : (c_day ? bcd_inc(date_ff) : date_ff);
    nxt_mon   = mon_ff;
    nxt_year  = year_ff;
    if (c_mon) begin
      nxt_mon  = (mon_ff == `BCD_12) ? `RST_ONE : bcd_inc(mon_ff);
      nxt_year = (mon_ff == `BCD_12) ?
                 ((year_ff == `BCD_MAX99) ? `RST_ZERO : bcd_inc(year_ff)) : year_ff;
    end
  end

  // Alarm is judged on the minute boundary against the new time
  wire alarm_hit = tick & c_min &
    (ext_ff[`REG_MIN_ALM][`ALM_MASK]  | (nxt_min == (ext_ff[`REG_MIN_ALM] & `WM_SEC))) &
    (ext_ff[`REG_HOUR_ALM][`ALM_MASK] | (nxt_hour[6:0] == ext_ff[`REG_HOUR_ALM][6:0])) &
    (ext_ff[`REG_DAY_ALM][`ALM_MASK]  | (nxt_day == (ext_ff[`REG_DAY_ALM] & `WM_DAY)));

  // ****************************************************************
  // Watchdog
  // ****************************************************************
  reg  [13:0] wd_cnt_ff;
  reg         wd_reload_ff;
  wire [13:0] wd_load = {bcd_to_bin(ext_ff[`REG_WD_HI]), 6'b000000}
                      + {1'b0, bcd_to_bin(ext_ff[`REG_WD_HI]), 5'b00000}
                      + {4'b0000, bcd_to_bin(ext_ff[`REG_WD_HI]), 2'b00}
                      + {7'b0000000, bcd_to_bin(ext_ff[`REG_WD_LO])};
  wire        wd_on   = (wd_load != 14'h0000);
  wire        wd_fire = tick & wd_on & (wd_cnt_ff <= 14'h0001);

  // ****************************************************************
  // Register file and timekeeping state
  // ****************************************************************
  integer i;

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (i = 0; i < `NUM_TK_REGS; i = i + 1) begin
        ext_ff[i] <= rst_val(i[3:0]);
      end
      hund_ff   <= `RST_ZERO;
      sec_ff    <= `RST_ZERO;
      min_ff    <= `RST_ZERO;
      hour_ff   <= `RST_ZERO;
      day_ff    <= `RST_ONE;
      date_ff   <= `RST_ONE;
      mon_ff    <= `RST_ONE;
      year_ff   <= `RST_ZERO;
      wd_cnt_ff <= 14'h0000;
      wd_reload_ff <= 1'b0;
    end else begin
      if (tick) begin
        {hund_ff, sec_ff, min_ff, hour_ff} <= {nxt_hund, nxt_sec, nxt_min, nxt_hour};
        {day_ff, date_ff, mon_ff, year_ff} <= {nxt_day, nxt_date, nxt_mon, nxt_year};
        if (ext_ff[`REG_CMD][`CMD_TE]) begin
          ext_ff[`REG_HUND]  <= nxt_hund;
          ext_ff[`REG_SEC]   <= nxt_sec;
          ext_ff[`REG_MIN]   <= nxt_min;
          ext_ff[`REG_HOUR]  <= nxt_hour;
          ext_ff[`REG_DAY]   <= nxt_day;
          ext_ff[`REG_DATE]  <= nxt_date;
          ext_ff[`REG_MONTH] <= (ext_ff[`REG_MONTH] & ~`WM_MON_FIELD) | nxt_mon;
          ext_ff[`REG_YEAR]  <= nxt_year;
        end
        if (wd_on) begin
          wd_cnt_ff <= wd_fire ? wd_load : wd_cnt_ff - 1'b1;
        end
      end
      // Host write lands after the tick so it wins for its own field only
      if (wr_reg) begin
        ext_ff[wr_idx] <= (wr_data_ff & wr_mask(wr_idx)) |
                          (ext_ff[wr_idx] & ~wr_mask(wr_idx));
        case (wr_idx)
          `REG_HUND:  hund_ff <= wr_data_ff;
          `REG_SEC:   sec_ff  <= wr_data_ff & `WM_SEC;
          `REG_MIN:   min_ff  <= wr_data_ff & `WM_SEC;
          `REG_HOUR:  hour_ff <= wr_data_ff & `WM_HOUR;
          `REG_DAY:   day_ff  <= wr_data_ff & `WM_DAY;
          `REG_DATE:  date_ff <= wr_data_ff & `WM_DATE;
          `REG_MONTH: mon_ff  <= wr_data_ff & `WM_MON_FIELD;
          `REG_YEAR:  year_ff <= wr_data_ff;
          default:    year_ff <= tick ? nxt_year : year_ff;
        endcase
      end
      // Flags: access clears, a same-cycle event sets and wins
      // Reload a cycle late so a host write to the interval counts from the new value
      wd_reload_ff <= wd_access;
      if (wd_access) begin
        ext_ff[`REG_CMD][`CMD_WDF] <= 1'b0;
      end
      if (wd_reload_ff) begin
        wd_cnt_ff <= wd_load;
      end
      if (alm_access) begin
        ext_ff[`REG_CMD][`CMD_TDF] <= 1'b0;
      end
      if (wd_fire) begin
        ext_ff[`REG_CMD][`CMD_WDF] <= 1'b1;
      end
      if (alarm_hit) begin
        ext_ff[`REG_CMD][`CMD_TDF] <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // User memory and read path
  // ****************************************************************
  wire [7:0] mem_rd;

  user_ram #(
    .ADDR_W (ADDR_W),
    .DATA_W (`DATA_W),
    .DEPTH  (MEM_DEPTH)
  ) u_ram (
    .clock   (clock),
    .wr_en   (commit & ~(wr_addr_ff < `NUM_TK_REGS)),
    .wr_addr (wr_addr_ff),
    .wr_data (wr_data_ff),
    .rd_addr (s_addr),
    .rd_data (mem_rd)
  );

  reg       sel_reg_ff;
  reg [7:0] reg_rd_ff;
  reg [7:0] data_out_ff;
  reg       irq_a_ff;
  reg       irq_b_ff;

  wire tod_irq = ext_ff[`REG_CMD][`CMD_TDF] & ~ext_ff[`REG_CMD][`CMD_TAM];
  wire wd_irq  = ext_ff[`REG_CMD][`CMD_WDF] & ~ext_ff[`REG_CMD][`CMD_WAM];

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sel_reg_ff  <= 1'b0;
      reg_rd_ff   <= 8'h00;
      data_out_ff <= 8'h00;
      irq_a_ff    <= 1'b0;
      irq_b_ff    <= 1'b0;
    end else begin
      sel_reg_ff  <= is_reg;
      reg_rd_ff   <= ext_ff[rd_idx];
      data_out_ff <= sel_reg_ff ? reg_rd_ff : mem_rd;
      // Interrupts ignore supply protection
      irq_a_ff    <= ext_ff[`REG_CMD][`CMD_IPSW] ? tod_irq : wd_irq;
      irq_b_ff    <= ext_ff[`REG_CMD][`CMD_IPSW] ? wd_irq : tod_irq;
    end
  end

  // Drivers follow the live read condition, so a falling write strobe
  // releases the bus even while select and output strobe stay low.
  assign data_io_oe        = rd_act;
  assign data_io_out       = data_out_ff;
  assign interrupt_out_a_b = ~irq_a_ff;
  assign interrupt_out_b_b = ~irq_b_ff;

endmodule // timekeeper_port

// ---- sim/timekeeper_port_properties.sv ----
`timescale 1ns/10ps
// ************
// Bus checks
// ************
module timekeeper_port_properties #(parameter ADDR_W = 15, parameter SETTLE_CYCLES = 20) (
  // Design ports
  input wire              clock,
  input wire              rst_b,
  input wire [ADDR_W-1:0] addr_in,
  input wire [7:0]        data_io_out,
  input wire              data_io_oe,
  input wire              chip_sel_b,
  input wire              out_strobe_b,
  input wire              wr_strobe_b,
  input wire              supply_fail,
  input wire              supply_good
);
  wire rd_pin = !chip_sel_b && !out_strobe_b && wr_strobe_b;
  logic [15:0] good_ff;
  logic [5:0] hold_ff;
  logic [ADDR_W-1:0] addr_ff;
  always @(posedge clock) addr_ff <= addr_in;
  // Pin-side count; the design sees supply late, so it only ever lags this
  always @(posedge clock or negedge rst_b)
    if (!rst_b) good_ff <= 16'h0000;
    else if (supply_fail || !supply_good) good_ff <= 16'h0000;
    else if (good_ff != 16'hFFFF) good_ff <= good_ff + 16'h0001;
  always @(posedge clock or negedge rst_b)
    if (!rst_b) hold_ff <= 6'h00;
    else if (!rd_pin || addr_in < 14 || addr_in != addr_ff) hold_ff <= 6'h00;
    else if (hold_ff != 6'h3F) hold_ff <= hold_ff + 6'h01;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  property p_oe_cause; data_io_oe |-> $past(rd_pin,3) || $past(rd_pin,4) || $past(rd_pin,5);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("drive without read");
  property p_oe_rise; (rd_pin && good_ff > SETTLE_CYCLES + 8)[*7] |-> data_io_oe; endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("read not driven");
  property p_we_kill; data_io_oe && $fell(wr_strobe_b) |-> ##[1:6] !data_io_oe; endproperty
  a_we_kill: assert property (p_we_kill) else $error("drive kept in write");
  property p_fail; supply_fail[*6] |-> !data_io_oe; endproperty
  a_fail: assert property (p_fail) else $error("drive in supply fail");
  property p_settle; $rose(data_io_oe) |-> good_ff >= SETTLE_CYCLES; endproperty
  a_settle: assert property (p_settle) else $error("drive before settle");
  property p_mem_hold; hold_ff >= 6'h0A |-> $stable(data_io_out); endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("memory data moved");
  property p_cs_off; chip_sel_b[*6] |-> !data_io_oe; endproperty
  a_cs_off: assert property (p_cs_off) else $error("drive unselected");
  property p_we_off; (!wr_strobe_b)[*6] |-> !data_io_oe; endproperty
  a_we_off: assert property (p_we_off) else $error("drive in write");
  c_read: cover property ($rose(data_io_oe));
  c_wr_in_rd: cover property (data_io_oe && $fell(wr_strobe_b));
  c_fail_rd: cover property (supply_fail && rd_pin);
endmodule  // timekeeper_port_properties

// ---- sim/host_bus_model.sv ----
`timescale 1ns/10ps
module host_bus_model (
  // Bus
  input wire         clock,
  input wire  [7:0]  dev_data,
  input wire         dev_oe,
  output logic [14:0] addr_in,
  output wire [7:0]  bus_data,
  output logic       chip_sel_b,
  output logic       out_strobe_b,
  output logic       wr_strobe_b
);
  logic [7:0] wd = 8'h00;
  logic [7:0] held = 8'h00;
  logic drv = 1'b0;
  // No keeper on the bus: a released bus wanders instead of holding
  assign bus_data = dev_oe ? dev_data : drv ? wd : ~held;
  always @(posedge clock) held <= bus_data;
  initial begin
    addr_in = 15'h0000;
    chip_sel_b = 1'b1;
    out_strobe_b = 1'b1;
    wr_strobe_b = 1'b1;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [14:0] a, input logic [7:0] d, input logic o);
    cyc(1);
    addr_in = a;
    wd = d;
    drv = 1'b1;
    out_strobe_b = o;
    chip_sel_b = 1'b0;
    cyc(o ? 1 : 8);
    wr_strobe_b = 1'b0;
    cyc(6);
    chip_sel_b = 1'b1;
    wr_strobe_b = 1'b1;
    cyc(6);
    drv = 1'b0;
    out_strobe_b = 1'b1;
    cyc(6);
  endtask
  task automatic rd(input logic [14:0] a, output logic [7:0] d);
    cyc(1);
    addr_in = a;
    chip_sel_b = 1'b0;
    out_strobe_b = 1'b0;
    cyc(12);
    d = bus_data;
    chip_sel_b = 1'b1;
    out_strobe_b = 1'b1;
    cyc(6);
  endtask
endmodule  // host_bus_model

// ---- sim/tb_top.sv ----
`timescale 1ns/10ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_count++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, a, e); end end
module tb_top;
  localparam SETTLE = 20;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic supply_fail = 1'b0;
  logic supply_good = 1'b1;
  wire [14:0] addr_in;
  wire [7:0] bus, dout;
  wire oe, cs_b, os_b, we_b, int_a_b, int_b_b;
  int err_count = 0;
  int n_tests = 0;
  logic [7:0] d;
  logic [7:0] tv [14] = '{8'h42, 8'h37, 8'h59, 8'h30, 8'h23, 8'h12, 8'h05, 8'h03,
                          8'h28, 8'h02, 8'h99, 8'h00, 8'h34, 8'h12};
  always #2 clock = ~clock;
  timekeeper_port #(.TICK_CYCLES(10), .SETTLE_CYCLES(SETTLE)) DUT (.clock(clock),
    .rst_b(rst_b), .addr_in(addr_in), .data_io_in(bus), .data_io_out(dout), .data_io_oe(oe),
    .chip_sel_b(cs_b), .out_strobe_b(os_b), .wr_strobe_b(we_b), .supply_fail(supply_fail),
    .supply_good(supply_good), .interrupt_out_a_b(int_a_b), .interrupt_out_b_b(int_b_b));
  host_bus_model host (.clock(clock), .dev_data(dout), .dev_oe(oe), .addr_in(addr_in),
    .bus_data(bus), .chip_sel_b(cs_b), .out_strobe_b(os_b), .wr_strobe_b(we_b));
  task automatic chk_rd(input logic [14:0] a, input logic [7:0] e);
    host.rd(a, d);
    `CHK(d, e)
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Whole sequence needs under 3000 cycles
  initial begin
    #100000;
    err_count++;
    end_of_test();
  end
  initial begin
    repeat (8) @(posedge clock);
    #1 rst_b = 1'b1;
    host.cyc(SETTLE + 20);
    `CHK({int_a_b, int_b_b}, 2'h3)
    chk_rd(15'h000B, 8'h8C);
    host.wr(15'h000B, 8'h0F, 1'b1);
    chk_rd(15'h000B, 8'h0C);
    $display("test command done");
    for (int i = 0; i < 14; i++) if (i != 11) host.wr(i[14:0], tv[i], 1'b1);
    for (int i = 0; i < 14; i++) if (i != 11) chk_rd(i[14:0], tv[i]);
    $display("test registers done");
    host.wr(15'h000E, 8'hA5, 1'b1);
    host.wr(15'h1234, 8'h5A, 1'b1);
    host.wr(15'h7FFF, 8'h3C, 1'b0);
    chk_rd(15'h000E, 8'hA5);
    chk_rd(15'h1234, 8'h5A);
    chk_rd(15'h7FFF, 8'h3C);
    $display("test memory done");
    host.wr(15'h000D, 8'h00, 1'b1);
    host.wr(15'h000C, 8'h02, 1'b1);
    host.wr(15'h000B, 8'h04, 1'b1);
    `CHK({int_a_b, int_b_b}, 2'h1)
    chk_rd(15'h000B, 8'h06);
    host.wr(15'h000B, 8'h0C, 1'b1);
    `CHK({int_a_b, int_b_b}, 2'h3)
    $display("test interrupt done");
    supply_fail = 1'b1;
    supply_good = 1'b0;
    host.wr(15'h000E, 8'hFF, 1'b1);
    host.rd(15'h000E, d);
    supply_fail = 1'b0;
    supply_good = 1'b1;
    host.cyc(SETTLE + 20);
    chk_rd(15'h000E, 8'hA5);
    $display("test supply done");
    end_of_test();
  end
endmodule  // tb_top
bind timekeeper_port timekeeper_port_properties #(.ADDR_W(ADDR_W),
  .SETTLE_CYCLES(SETTLE_CYCLES)) u_props (.clock(clock), .rst_b(rst_b), .addr_in(addr_in),
  .data_io_out(data_io_out), .data_io_oe(data_io_oe), .chip_sel_b(chip_sel_b),
  .out_strobe_b(out_strobe_b), .wr_strobe_b(wr_strobe_b), .supply_fail(supply_fail),
  .supply_good(supply_good));
